/* lac_alarm_ctrl.sv */
// apb register bank for line alarms, interrupts, loopback and monitor control
`timescale 1ns/1ps
`default_nettype none
`include "lac_alarm_regs.svh"

// Functional notes
// - driver short sets its status bit
// - signal loss change drives interrupt if enabled
// - driver fault change interrupts only if enabled
// - signal loss change sets its flag
// - driver fault change sets its flag
// - signal loss flags are sticky
// - driver fault flags are sticky
// - any soft reset write clears all registers
// - low nibble selects monitored channel path
// - loopback bit enables channel digital loopback
// - one selects etsi, zero selects g775
// - auto bit sends all ones on loss
// - every register resets to zero
// - signal loss status reads live detection
module lac_alarm_ctrl (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`LAC_ADDR_W-1:0] paddr,
	input wire logic [`LAC_DATA_W-1:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic pready,
	output logic [`LAC_DATA_W-1:0] prdata,
	output logic pslverr,
	input wire logic [`LAC_NCH-1:0] signal_absence_in,
	input wire logic [`LAC_NCH-1:0] driver_fault_monitor_in,
	output logic int_n,
	output logic [`LAC_MON_W-1:0] monitor_channel_sel,
	output logic [`LAC_NCH-1:0] digital_loop_en,
	output logic [`LAC_NCH-1:0] alarm_standard_etsi,
	output logic [`LAC_NCH-1:0] all_ones_transmit
);

	// -------------------------------------------------------------------------
	// address decode helpers
	// -------------------------------------------------------------------------
	function automatic logic lac_hit(
		input logic [`LAC_ADDR_W-1:0] addr,
		input logic [`LAC_IDX_W-1:0] idx
	);
		lac_hit = (addr == {idx, 2'b00});
	endfunction

	function automatic logic lac_mapped(input logic [`LAC_ADDR_W-1:0] addr);
		logic [`LAC_IDX_W-1:0] idx;
		idx = addr[`LAC_ADDR_W-1:2];
		lac_mapped = (addr[1:0] == 2'b00) && (idx >= `LAC_IDX_FIRST) &&
			(idx <= `LAC_IDX_LAST);
	endfunction

	// -------------------------------------------------------------------------
	// event paths
	// -------------------------------------------------------------------------
	lac_evt_if los_evt ();
	lac_evt_if dfm_evt ();

	lac_flag_unit u_los_flags (
		.pclk(pclk),
		.presetn(presetn),
		.evt(los_evt.unit)
	);

	lac_flag_unit u_dfm_flags (
		.pclk(pclk),
		.presetn(presetn),
		.evt(dfm_evt.unit)
	);

	// -------------------------------------------------------------------------
	// state
	// -------------------------------------------------------------------------
	lac_pkg::lac_bank_state_t s_q;
	lac_pkg::lac_bank_state_t s_d;
	logic access_c;
	logic first_c;
	logic done_c;
	logic wr_c;
	logic wr_lane_c;
	logic rd_done_c;
	logic srst_c;
	logic [`LAC_REG_W-1:0] rd_val_c;
	logic [`LAC_NCH-1:0] los_clr_c;
	logic [`LAC_NCH-1:0] dfm_clr_c;
	logic [`LAC_NCH-1:0] pending_c;
	logic [`LAC_NCH-1:0] los_pend_c;
	logic [`LAC_NCH-1:0] dfm_pend_c;

	// -------------------------------------------------------------------------
	// register decode strobes
	// -------------------------------------------------------------------------
	logic [`LAC_IDX_W-1:0] idx_c;
	logic mapped_c;
	logic wr_los_en_c;
	logic wr_dfm_en_c;
	logic wr_mon_c;
	logic wr_loop_c;
	logic wr_std_c;
	logic wr_ones_c;
	logic wc_los_c;
	logic wc_dfm_c;
	logic rc_los_c;
	logic rc_dfm_c;

	// -------------------------------------------------------------------------
	// next state
	// -------------------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		access_c = psel & penable;
		// one wait state: data is registered in the first access cycle
		first_c = access_c & ~s_q.pready;
		done_c = access_c & s_q.pready;
		wr_c = done_c & pwrite & ~s_q.pslverr;
		wr_lane_c = wr_c & pstrb[`LAC_STRB_LANE0];
		rd_done_c = done_c & ~pwrite & ~s_q.pslverr;

		// ---------------------------------------------------------------------
		// register decode
		// ---------------------------------------------------------------------
		idx_c = paddr[`LAC_ADDR_W-1:2];
		mapped_c = lac_mapped(paddr);
		// done strobes already exclude refused addresses, so the index alone decides
		wr_los_en_c = 1'b0;
		wr_dfm_en_c = 1'b0;
		wr_mon_c = 1'b0;
		wr_loop_c = 1'b0;
		wr_std_c = 1'b0;
		wr_ones_c = 1'b0;
		wc_los_c = 1'b0;
		wc_dfm_c = 1'b0;
		rc_los_c = 1'b0;
		rc_dfm_c = 1'b0;

		case (idx_c)
			`LAC_IDX_SIG_LOSS_IRQ_EN: begin
				wr_los_en_c = wr_lane_c;
			end
			`LAC_IDX_DRV_FAULT_IRQ_EN: begin
				wr_dfm_en_c = wr_lane_c;
			end
			`LAC_IDX_SIG_LOSS_FLAGS: begin
				wc_los_c = wr_lane_c;
				rc_los_c = rd_done_c;
			end
			`LAC_IDX_DRV_FAULT_FLAGS: begin
				wc_dfm_c = wr_lane_c;
				rc_dfm_c = rd_done_c;
			end
			`LAC_IDX_MON_SELECT: begin
				wr_mon_c = wr_lane_c;
			end
			`LAC_IDX_DIG_LOOP: begin
				wr_loop_c = wr_lane_c;
			end
			`LAC_IDX_ALARM_STD: begin
				wr_std_c = wr_lane_c;
			end
			`LAC_IDX_AUTO_ONES: begin
				wr_ones_c = wr_lane_c;
			end
			default: begin
				// status, soft reset and unmapped indices store nothing here
				wr_los_en_c = 1'b0;
			end
		endcase

		// ---------------------------------------------------------------------
		// read mux
		// ---------------------------------------------------------------------
		rd_val_c = `LAC_REG_RESET;
		case (idx_c)
			`LAC_IDX_SIG_LOSS_STATUS: begin
				rd_val_c = los_evt.status;
			end
			`LAC_IDX_DRV_FAULT_STATUS: begin
				rd_val_c = dfm_evt.status;
			end
			`LAC_IDX_SIG_LOSS_IRQ_EN: begin
				rd_val_c = s_q.los_irq_en;
			end
			`LAC_IDX_DRV_FAULT_IRQ_EN: begin
				rd_val_c = s_q.dfm_irq_en;
			end
			`LAC_IDX_SIG_LOSS_FLAGS: begin
				rd_val_c = los_evt.flags;
			end
			`LAC_IDX_DRV_FAULT_FLAGS: begin
				rd_val_c = dfm_evt.flags;
			end
			`LAC_IDX_SOFT_RESET: begin
				// write-only strobe, nothing is stored
				rd_val_c = `LAC_REG_RESET;
			end
			`LAC_IDX_MON_SELECT: begin
				rd_val_c = {{(`LAC_REG_W-`LAC_MON_W){1'b0}}, s_q.mon_sel};
			end
			`LAC_IDX_DIG_LOOP: begin
				rd_val_c = s_q.dig_loop;
			end
			`LAC_IDX_ALARM_STD: begin
				rd_val_c = s_q.alarm_std;
			end
			`LAC_IDX_AUTO_ONES: begin
				rd_val_c = s_q.auto_ones;
			end
			default: begin
				rd_val_c = `LAC_REG_RESET;
			end
		endcase

		// ---------------------------------------------------------------------
		// bus answer
		// ---------------------------------------------------------------------
		s_d.pready = first_c;
		s_d.pslverr = 1'b0;
		// read data stands only with pready, zero otherwise
		s_d.prdata = `LAC_DATA_RESET;
		if (first_c) begin
			s_d.pslverr = ~mapped_c;
			if (!pwrite && mapped_c) begin
				s_d.prdata = {{`LAC_PAD_W{1'b0}}, rd_val_c};
			end
		end

		// ---------------------------------------------------------------------
		// control registers
		// ---------------------------------------------------------------------
		if (wr_los_en_c) begin
			s_d.los_irq_en = pwdata[`LAC_NCH-1:0];
		end
		if (wr_dfm_en_c) begin
			s_d.dfm_irq_en = pwdata[`LAC_NCH-1:0];
		end
		if (wr_mon_c) begin
			// upper bits are reserved and never stored
			s_d.mon_sel = pwdata[`LAC_MON_MSB:`LAC_MON_LSB];
		end
		if (wr_loop_c) begin
			s_d.dig_loop = pwdata[`LAC_NCH-1:0];
		end
		if (wr_std_c) begin
			s_d.alarm_std = pwdata[`LAC_NCH-1:0];
		end
		if (wr_ones_c) begin
			s_d.auto_ones = pwdata[`LAC_NCH-1:0];
		end

		// ---------------------------------------------------------------------
		// flag clearing
		// ---------------------------------------------------------------------
		// only the bits the host actually saw, so late events survive
		los_clr_c = `LAC_REG_RESET;
		dfm_clr_c = `LAC_REG_RESET;
		if (rc_los_c) begin
			los_clr_c = s_q.prdata[`LAC_NCH-1:0];
		end
		if (rc_dfm_c) begin
			dfm_clr_c = s_q.prdata[`LAC_NCH-1:0];
		end
		if (wc_los_c) begin
			los_clr_c = pwdata[`LAC_NCH-1:0];
		end
		if (wc_dfm_c) begin
			dfm_clr_c = pwdata[`LAC_NCH-1:0];
		end

		// ---------------------------------------------------------------------
		// line-side outputs
		// ---------------------------------------------------------------------
		s_d.all_ones_tx = s_q.auto_ones & los_evt.status;
		// enables double as the interrupt mask
		los_pend_c = los_evt.flags & s_q.los_irq_en;
		dfm_pend_c = dfm_evt.flags & s_q.dfm_irq_en;
		pending_c = los_pend_c | dfm_pend_c;
		s_d.int_n = ~(|pending_c);

		// ---------------------------------------------------------------------
		// soft reset: any write, any value, any lane
		// ---------------------------------------------------------------------
		srst_c = wr_c && lac_hit(paddr, `LAC_IDX_SOFT_RESET);
		if (srst_c) begin
			s_d.los_irq_en = `LAC_REG_RESET;
			s_d.dfm_irq_en = `LAC_REG_RESET;
			s_d.mon_sel = `LAC_MON_RESET;
			s_d.dig_loop = `LAC_REG_RESET;
			s_d.alarm_std = `LAC_REG_RESET;
			s_d.auto_ones = `LAC_REG_RESET;
			s_d.all_ones_tx = `LAC_REG_RESET;
			s_d.int_n = `LAC_INT_N_RESET;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '{
				pready: 1'b0,
				pslverr: 1'b0,
				prdata: `LAC_DATA_RESET,
				los_irq_en: `LAC_REG_RESET,
				dfm_irq_en: `LAC_REG_RESET,
				mon_sel: `LAC_MON_RESET,
				dig_loop: `LAC_REG_RESET,
				alarm_std: `LAC_REG_RESET,
				auto_ones: `LAC_REG_RESET,
				all_ones_tx: `LAC_REG_RESET,
				int_n: `LAC_INT_N_RESET
			};
		end else begin
			s_q <= s_d;
		end
	end

	// -------------------------------------------------------------------------
	// connections
	// -------------------------------------------------------------------------
	assign los_evt.live = signal_absence_in;
	assign los_evt.clr = los_clr_c;
	assign los_evt.srst = srst_c;
	assign dfm_evt.live = driver_fault_monitor_in;
	assign dfm_evt.clr = dfm_clr_c;
	assign dfm_evt.srst = srst_c;

	assign pready = s_q.pready;
	assign prdata = s_q.prdata;
	assign pslverr = s_q.pslverr;
	assign int_n = s_q.int_n;
	assign monitor_channel_sel = s_q.mon_sel;
	assign digital_loop_en = s_q.dig_loop;
	assign alarm_standard_etsi = s_q.alarm_std;
	assign all_ones_transmit = s_q.all_ones_tx;

endmodule // lac_alarm_ctrl
`default_nettype wire

/* lac_alarm_ctrl_asserts.sv */
// port checker of the alarm register bank
`timescale 1ns/1ps
`default_nettype none
`include "lac_alarm_regs.svh"
module lac_alarm_ctrl_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`LAC_ADDR_W-1:0] paddr,
	input wire logic [`LAC_DATA_W-1:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic pready,
	input wire logic [`LAC_DATA_W-1:0] prdata,
	input wire logic pslverr,
	input wire logic [`LAC_NCH-1:0] signal_absence_in,
	input wire logic int_n,
	input wire logic [`LAC_MON_W-1:0] monitor_channel_sel,
	input wire logic [`LAC_NCH-1:0] digital_loop_en,
	input wire logic [`LAC_NCH-1:0] alarm_standard_etsi,
	input wire logic [`LAC_NCH-1:0] all_ones_transmit
);
	// ----
	// checks
	// ----
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire logic acc = psel && penable;
	wire logic done = acc && pready;
	wire logic bad = paddr[1:0] != 2'h0 || paddr[7:2] < 6'h04 || paddr[7:2] > 6'h0E;
	// byte helper keeps $past on a plain signal
	wire logic [7:0] wbyte = pwdata[7:0];
	property p_wr(logic [7:0] a, logic [7:0] o);
		done && pwrite && pstrb[0] && !pslverr && paddr == a |=> o == $past(wbyte);
	endproperty
	a_one_wait: assert property (acc && !pready |=> pready)
		else $error("no answer after access");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held");
	a_idle_quiet: assert property (!acc |=> !pready)
		else $error("ready while idle");
	a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("read data while idle");
	a_err_map: assert property (done |-> pslverr == bad)
		else $error("error flag wrong");
	a_srst_clear: assert property (done && pwrite && paddr == 8'h28 |=>
		monitor_channel_sel == 4'h0 && digital_loop_en == 8'h0 && alarm_standard_etsi == 8'h0
		&& all_ones_transmit == 8'h0 && int_n) else $error("soft reset left state");
	a_mon_write: assert property (p_wr(8'h2C, {4'h0, monitor_channel_sel}))
		else $error("monitor select not stored");
	a_loop_write: assert property (p_wr(8'h30, digital_loop_en))
		else $error("loopback not stored");
	a_std_write: assert property (p_wr(8'h34, alarm_standard_etsi))
		else $error("standard not stored");
	a_ones_loss: assert property ((all_ones_transmit & ~$past(signal_absence_in, 2)) == 8'h0)
		else $error("all ones without loss");
	cover property (done && pslverr);
	cover property ($fell(int_n));
	cover property (|all_ones_transmit);
endmodule // lac_alarm_ctrl_chk
`default_nettype wire

/* lac_alarm_ctrl_tb.sv */
// self-checking bench of the alarm register bank
`timescale 1ns/1ps
`default_nettype none
`include "lac_alarm_regs.svh"
module lac_alarm_ctrl_tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, int_n;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] pstrb, mon;
	logic [7:0] signal_absence = 8'h00, driver_fault_monitor = 8'h00, loop_en, std_en, ones;
	int num_errors = 0, cmp_count = 0, lf = 0, df = 0, ex[16];
	integer seed = 32'h6ED2;
	always #2 pclk = ~pclk;
	lac_host i_lac_host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.pready, .prdata, .pslverr);
	lac_alarm_ctrl i_lac_alarm_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pstrb, .pready, .prdata, .pslverr, .signal_absence_in(signal_absence),
		.driver_fault_monitor_in(driver_fault_monitor), .int_n, .monitor_channel_sel(mon),
		.digital_loop_en(loop_en), .alarm_standard_etsi(std_en), .all_ones_transmit(ones));
	// ----
	// tasks
	// ----
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rd(input int i);
		logic [31:0] q, x;
		logic e;
		case (i)
			4: x = signal_absence;
			5: x = driver_fault_monitor;
			8: x = lf;
			9: x = df;
			default: x = ex[i];
		endcase
		i_lac_host.xfer(1'b0, 8'(i * 4), 32'h0, q, e);
		chk(q, x);
		chk(32'(e), 32'(i < 4 || i > 14));
	endtask
	task automatic wr(input int i, input int d);
		logic [31:0] q;
		logic e;
		i_lac_host.xfer(1'b1, 8'(i * 4), d, q, e);
	endtask
	task automatic pins;
		repeat (2) @(posedge pclk);
		chk({int_n, mon, loop_en, std_en, ones}, {!(|((lf & ex[6]) | (df & ex[7]))),
			ex[11][3:0], ex[12][7:0], ex[13][7:0], ex[14][7:0] & signal_absence});
	endtask
	task automatic line(input logic [7:0] a, input logic [7:0] b);
		@(posedge pclk);
		lf |= signal_absence ^ a;
		df |= driver_fault_monitor ^ b;
		signal_absence <= a;
		driver_fault_monitor <= b;
		repeat (4) @(posedge pclk);
	endtask
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// ----
	// sequence
	// ----
	initial begin
		#40000;
		num_errors++;
		give_verdict;
	end
	initial begin
		ex = '{default: 0};
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 16; i++) rd(i);
		$display("reset values done");
		for (int i = 6; i < 15; i++) begin
			if (i < 8 || i > 10) begin
				ex[i] = $random(seed) & (i == 11 ? 15 : 255);
				wr(i, ex[i]);
				rd(i);
			end
		end
		pins;
		$display("config done");
		repeat (5) begin
			line(8'($random(seed)), 8'($random(seed)));
			line(8'($random(seed)), 8'($random(seed)));
			pins;
			rd(4);
			rd(5);
			rd(8);
			lf = 0;
			rd(9);
			df = 0;
			rd(8);
			pins;
		end
		line(~signal_absence, ~driver_fault_monitor);
		wr(8, lf);
		wr(9, df);
		lf = 0;
		df = 0;
		rd(8);
		rd(9);
		pins;
		$display("events done");
		wr(10, $random(seed));
		ex = '{default: 0};
		lf = 0;
		df = 0;
		repeat (2) @(posedge pclk);
		for (int i = 4; i < 15; i++) rd(i);
		pins;
		$display("soft reset done");
		give_verdict;
	end
endmodule // lac_alarm_ctrl_tb
bind lac_alarm_ctrl lac_alarm_ctrl_chk i_lac_alarm_ctrl_chk (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr,
	.signal_absence_in, .int_n, .monitor_channel_sel, .digital_loop_en,
	.alarm_standard_etsi, .all_ones_transmit);
`default_nettype wire

/* lac_alarm_regs.svh */
// register indices, field positions, widths and reset values of the alarm control group
`ifndef LAC_ALARM_REGS_SVH
`define LAC_ALARM_REGS_SVH

// -----------------------------------------------------------------------------
// geometry
// -----------------------------------------------------------------------------
`define LAC_NCH 8
`define LAC_IDX_W 6
`define LAC_ADDR_W 8
`define LAC_DATA_W 32
`define LAC_REG_W 8
`define LAC_PAD_W 24
`define LAC_MON_W 4

// -----------------------------------------------------------------------------
// register indices (byte address is four times the index)
// -----------------------------------------------------------------------------
`define LAC_IDX_SIG_LOSS_STATUS 6'h04
`define LAC_IDX_DRV_FAULT_STATUS 6'h05
`define LAC_IDX_SIG_LOSS_IRQ_EN 6'h06
`define LAC_IDX_DRV_FAULT_IRQ_EN 6'h07
`define LAC_IDX_SIG_LOSS_FLAGS 6'h08
`define LAC_IDX_DRV_FAULT_FLAGS 6'h09
`define LAC_IDX_SOFT_RESET 6'h0A
`define LAC_IDX_MON_SELECT 6'h0B
`define LAC_IDX_DIG_LOOP 6'h0C
`define LAC_IDX_ALARM_STD 6'h0D
`define LAC_IDX_AUTO_ONES 6'h0E
`define LAC_IDX_FIRST 6'h04
`define LAC_IDX_LAST 6'h0E

// -----------------------------------------------------------------------------
// fields and reset values
// -----------------------------------------------------------------------------
`define LAC_MON_LSB 0
`define LAC_MON_MSB 3
`define LAC_STRB_LANE0 0
`define LAC_REG_RESET 8'h00
`define LAC_MON_RESET 4'h0
`define LAC_DATA_RESET 32'h0000_0000
`define LAC_INT_N_RESET 1'b1

`endif

/* lac_evt_if.sv */
// channel event path between the register bank and a flag unit
`timescale 1ns/1ps
`default_nettype none
`include "lac_alarm_regs.svh"
interface lac_evt_if;
	logic [`LAC_NCH-1:0] live;
	logic [`LAC_NCH-1:0] clr;
	logic srst;
	logic [`LAC_NCH-1:0] status;
	logic [`LAC_NCH-1:0] flags;

	modport bank (
		output live,
		output clr,
		output srst,
		input status,
		input flags
	);
	modport unit (
		input live,
		input clr,
		input srst,
		output status,
		output flags
	);
endinterface
`default_nettype wire

/* lac_flag_unit.sv */
// per-channel status mirror with sticky change flags
`timescale 1ns/1ps
`default_nettype none
`include "lac_alarm_regs.svh"
module lac_flag_unit (
	input wire logic pclk,
	input wire logic presetn,
	lac_evt_if.unit evt
);
	lac_pkg::lac_flag_state_t s_q;
	lac_pkg::lac_flag_state_t s_d;
	lac_pkg::lac_chan_t set_c;

	// -------------------------------------------------------------------------
	// next state
	// -------------------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.hold = 1'b0;
		s_d.status = evt.live;
		// first cycle after a soft reset re-learns the lines without flagging them
		set_c = (evt.live ^ s_q.status) & {`LAC_NCH{~s_q.hold}};
		s_d.flags = (s_q.flags & ~evt.clr) | set_c;
		if (evt.srst) begin
			s_d.status = `LAC_REG_RESET;
			s_d.flags = `LAC_REG_RESET;
			s_d.hold = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '{status: `LAC_REG_RESET, flags: `LAC_REG_RESET, hold: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign evt.status = s_q.status;
	assign evt.flags = s_q.flags;
endmodule // lac_flag_unit
`default_nettype wire

/* lac_host.sv */
// apb host model for the alarm register bank
`timescale 1ns/1ps
`default_nettype none
`include "lac_alarm_regs.svh"
module lac_host (
	input wire logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [`LAC_ADDR_W-1:0] paddr,
	output logic [`LAC_DATA_W-1:0] pwdata,
	output logic [3:0] pstrb,
	input wire logic pready,
	input wire logic [`LAC_DATA_W-1:0] prdata,
	input wire logic pslverr
);
	// ----
	// transfer
	// ----
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pstrb = 4'h0;
	end
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		logic [31:0] wd;
		wd = (a == 8'h2C) ? {28'h0, d[3:0]} : d;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		pstrb <= w ? 4'hF : 4'h0;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// released data must not look valid
		pwdata <= ~wd;
	endtask
endmodule // lac_host
`default_nettype wire

/* lac_pkg.sv */
// state types of the alarm control register group
`default_nettype none
package lac_pkg;
`include "lac_alarm_regs.svh"

	typedef logic [`LAC_NCH-1:0] lac_chan_t;

	// -------------------------------------------------------------------------
	// flag unit state
	// -------------------------------------------------------------------------
	typedef struct packed {
		lac_chan_t status;
		lac_chan_t flags;
		logic hold;
	} lac_flag_state_t;

	// -------------------------------------------------------------------------
	// register bank state
	// -------------------------------------------------------------------------
	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [`LAC_DATA_W-1:0] prdata;
		lac_chan_t los_irq_en;
		lac_chan_t dfm_irq_en;
		logic [`LAC_MON_W-1:0] mon_sel;
		lac_chan_t dig_loop;
		lac_chan_t alarm_std;
		lac_chan_t auto_ones;
		lac_chan_t all_ones_tx;
		logic int_n;
	} lac_bank_state_t;

endpackage
`default_nettype wire
